/* File: autoneg_next_page_tx_regs.v */
// next page transmit and crossover status registers behind an apb slave
// assumes one clock, synchronous inputs from the arbitration logic and
// the crossover engine; apb answers with no wait state
`timescale 1ns/10ps
`include "np_consts.vh"
module autoneg_next_page_tx_regs (
  // clock and reset
  input  wire                 pclk,
  input  wire                 presetn,

  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`ADDR_W-1:0]   paddr,
  input  wire [31:0]          pwdata,
  output wire                 pready,
  output reg  [31:0]          prdata,
  output reg                  pslverr,

  // auto-negotiation arbitration side
  input  wire                 word_sent,
  input  wire                 word_toggle,
  input  wire                 page_received,
  output reg  [15:0]          next_page_word,
  output reg                  next_page_loaded_r,

  // crossover engine side
  input  wire                 auto_swapped,
  output wire                 crossover_status,
  output reg                  pair_swap_r
);

  // register state
  reg                     more_pages_flag_r;
  reg                     page_type_message_r;
  reg                     comply_acknowledge_r;
  reg [`PG_CODE_W-1:0]    code_r;
  reg                     page_rx_r;
  reg                     auto_crossover_enable_r;
  reg                     crossover_force_r;

  wire                    transmit_toggle;

  // bus decode
  wire [7:0]              idx;
  wire                    aligned;
  wire                    hit_exp;
  wire                    hit_npt;
  wire                    hit_sts;
  wire                    hit_ctl;
  wire                    mapped;
  wire                    setup_ph;
  wire                    access_done;
  wire                    wr_done;
  wire                    rd_done;

  reg  [15:0]             rd_mux;
  reg  [15:0]             npt_view;
  reg  [15:0]             exp_view;
  reg  [15:0]             sts_view;
  reg  [15:0]             ctl_view;

  assign idx         = paddr[9:2];
  assign aligned     = (paddr[1:0] == 2'b00) &&
                       (paddr[`ADDR_W-1:10] == 2'b00);
  assign hit_exp     = aligned && (idx == `IDX_AUTONEG_EXPANSION);
  assign hit_npt     = aligned && (idx == `IDX_NEXT_PAGE_TRANSMIT);
  assign hit_sts     = aligned && (idx == `IDX_PHY_STATUS_SUMMARY);
  assign hit_ctl     = aligned && (idx == `IDX_PHY_CONTROL);
  assign mapped      = hit_exp | hit_npt | hit_sts | hit_ctl;

  // zero wait state slave: every access phase completes at once
  assign pready      = 1'b1;
  assign setup_ph    = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done     = access_done & pwrite & mapped;
  assign rd_done     = access_done & ~pwrite;

  // toggle handed to the arbitration logic
  toggle_tracker u_toggle (
    .pclk              (pclk),
    .presetn           (presetn),
    .word_sent         (word_sent),
    .word_toggle       (word_toggle),
    .transmit_toggle_r (transmit_toggle)
  );

  // crossover state reported in the status register
  crossover_tracker u_xover (
    .pclk                  (pclk),
    .presetn               (presetn),
    .auto_crossover_enable (auto_crossover_enable_r),
    .crossover_force       (crossover_force_r),
    .auto_swapped          (auto_swapped),
    .crossover_status_r    (crossover_status)
  );

  // register views as software sees them
  always @* begin
    npt_view                     = 16'h0000;
    npt_view[`PG_MORE_PAGES_BIT] = more_pages_flag_r;
    npt_view[`PG_RESERVED_BIT]   = 1'b0;
    npt_view[`PG_PAGE_TYPE_BIT]  = page_type_message_r;
    npt_view[`PG_COMPLY_ACK_BIT] = comply_acknowledge_r;
    npt_view[`PG_TOGGLE_BIT]     = transmit_toggle;
    npt_view[`PG_CODE_MSB:0]     = code_r;
  end

  always @*  begin
    exp_view                          = 16'h0000;
    exp_view[`EXP_NEXT_PAGE_ABLE_BIT] = 1'b1;
    exp_view[`EXP_PAGE_RX_BIT]        = page_rx_r;
  end

  always @* begin
    sts_view                 = 16'h0000;
    sts_view[`STS_XOVER_BIT] = crossover_status;
  end

  always @* begin
    ctl_view                       = 16'h0000;
    ctl_view[`CTL_XOVER_EN_BIT]    = auto_crossover_enable_r;
    ctl_view[`CTL_XOVER_FORCE_BIT] = crossover_force_r;
  end

  always @* begin
    if (hit_npt) begin
      rd_mux = npt_view;
    end else if (hit_exp) begin
      rd_mux = exp_view;
    end else if (hit_sts) begin
      rd_mux = sts_view;
    end else if (hit_ctl) begin
      rd_mux = ctl_view;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // read data and error are captured in the setup phase so they come
  // from flip-flops and stand through the single access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= {16'h0000, rd_mux};
      pslverr <= ~mapped;
    end else if (access_done) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // next page transmit fields; bits 14 and 11 of a write are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      more_pages_flag_r    <= `PG_MORE_PAGES_RST;
      page_type_message_r  <= `PG_PAGE_TYPE_RST;
      comply_acknowledge_r <= `PG_COMPLY_ACK_RST;
      code_r               <= `PG_CODE_RST;
    end else if (wr_done && hit_npt) begin
      more_pages_flag_r    <= pwdata[`PG_MORE_PAGES_BIT];
      page_type_message_r  <= pwdata[`PG_PAGE_TYPE_BIT];
      comply_acknowledge_r <= pwdata[`PG_COMPLY_ACK_BIT];
      code_r               <= pwdata[`PG_CODE_MSB:0];
    end
  end

  // crossover controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_crossover_enable_r <= `CTL_XOVER_EN_RST;
      crossover_force_r       <= `CTL_XOVER_FORCE_RST;
    end else if (wr_done && hit_ctl) begin
      auto_crossover_enable_r <= pwdata[`CTL_XOVER_EN_BIT];
      crossover_force_r       <= pwdata[`CTL_XOVER_FORCE_BIT];
    end
  end

  // page received: a word arriving in the clearing read is kept; only a
  // flag that the captured read data reported is cleared, so a word that
  // lands at the setup edge is not lost unseen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_rx_r <= 1'b0;
    end else if (page_received) begin
      page_rx_r <= 1'b1;
    end else if (rd_done && hit_exp && prdata[`EXP_PAGE_RX_BIT]) begin
      page_rx_r <= 1'b0;
    end
  end

  // a full word lands in one write, so the page the arbitration logic
  // sees is never half updated; loaded marks a page not yet sent
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_page_loaded_r <= 1'b0;
    end else if (wr_done && hit_npt) begin
      next_page_loaded_r <= 1'b1;
    end else if (word_sent) begin
      next_page_loaded_r <= 1'b0;
    end
  end

  // page word presented to the arbitration logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_page_word <= {`PG_MORE_PAGES_RST, 1'b0, `PG_PAGE_TYPE_RST,
                         `PG_COMPLY_ACK_RST, `PG_TOGGLE_RST,
                         `PG_CODE_RST};
    end else begin
      next_page_word <= npt_view;
    end
  end

  // pair steering follows the reported state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_swap_r <= 1'b0;
    end else begin
      pair_swap_r <= crossover_status;
    end
  end

endmodule // autoneg_next_page_tx_regs

/* File: autoneg_next_page_tx_regs_chk.sv */
// assertions for the next page transmit and crossover status slice
// assumes control index 0x19 resets to enable set, force clear
`timescale 1ns/10ps
`include "np_consts.vh"
module autoneg_next_page_tx_regs_chk (
  // clock and reset
  input wire               pclk,
  input wire               presetn,
  // apb
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0]        pwdata,
  input wire               pready,
  input wire [31:0]        prdata,
  input wire               pslverr,
  // arbitration and crossover
  input wire               word_sent,
  input wire               word_toggle,
  input wire [15:0]        next_page_word,
  input wire               next_page_loaded_r,
  input wire               auto_swapped,
  input wire               crossover_status
);
  wire       acc = psel && penable;
  wire [7:0] ix  = paddr[9:2];
  wire       map = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00 &&
    (ix == 8'h06 || ix == 8'h07 || ix == 8'h10 || ix == 8'h19);
  wire       page_wr = acc && pwrite && paddr == 12'h01C;
  // shadow of the control bits, needed to predict the status bit
  reg        en_r;
  reg        fr_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b1;
      fr_r <= 1'b0;
    end else if (acc && pwrite && paddr == 12'h064) begin
      en_r <= pwdata[15];
      fr_r <= pwdata[14];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; acc |-> pready; endproperty
  property p_idle; !acc |-> prdata == 32'h0000_0000 && !pslverr; endproperty
  property p_err; acc |-> pslverr == !map; endproperty
  property p_rsv; acc && !pwrite && paddr == 12'h01C |-> !prdata[14];
  endproperty
  property p_sts; acc && !pwrite && paddr == 12'h040 |-> !prdata[15];
  endproperty
  property p_tog;
    word_sent |-> ##2 next_page_word[11] == !$past(word_toggle, 2);
  endproperty
  property p_wr;
    page_wr |-> ##2 {next_page_word[15:12], next_page_word[10:0]} ==
      {$past(pwdata[15], 2), 1'b0, $past(pwdata[13:12], 2),
       $past(pwdata[10:0], 2)};
  endproperty
  property p_ld; page_wr |=> next_page_loaded_r; endproperty
  property p_xo;
    1'b1 |=> crossover_status ==
      ($past(fr_r) || ($past(en_r) && $past(auto_swapped)));
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  a_idle: assert property (p_idle) else $error("idle bus not 0");
  a_err: assert property (p_err) else $error("slverr wrong");
  a_rsv: assert property (p_rsv) else $error("page bit14 set");
  a_sts: assert property (p_sts) else $error("sts bit15 set");
  a_tog: assert property (p_tog) else $error("toggle wrong");
  a_wr: assert property (p_wr) else $error("page fields");
  a_ld: assert property (p_ld) else $error("loaded not set");
  a_xo: assert property (p_xo) else $error("crossover");
  c_tog: cover property (word_sent);
  c_err: cover property (acc && pslverr);
  c_xo: cover property ($rose(crossover_status));
endmodule // autoneg_next_page_tx_regs_chk

bind autoneg_next_page_tx_regs autoneg_next_page_tx_regs_chk i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .word_sent, .word_toggle, .next_page_word,
  .next_page_loaded_r, .auto_swapped, .crossover_status);

/* File: crossover_tracker.v */
// crossover status tracker
// assumes auto_swapped is a synchronous level from the auto crossover engine
`timescale 1ns/10ps
`include "np_consts.vh"
module crossover_tracker (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // control bits
  input  wire auto_crossover_enable,
  input  wire crossover_force,
  // automatic algorithm choice, 1 swapped
  input  wire auto_swapped,
  // reported crossover state
  output reg  crossover_status_r
);

  reg crossover_status_nxt;

  // force wins over the automatic choice and over disable; disabled without force means normal pairing
  always @* begin
    if (crossover_force) begin
      crossover_status_nxt = 1'b1;
    end else if (auto_crossover_enable) begin
      crossover_status_nxt = auto_swapped;
    end else begin
      crossover_status_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossover_status_r <= `STS_XOVER_RST;
    end else begin
      crossover_status_r <= crossover_status_nxt;
    end
  end

endmodule // crossover_tracker

/* File: link_partner_model.sv */
// link partner exchange and crossover engine model
// assumes tasks are called from the bench just after a rising edge
`timescale 1ns/10ps
module link_partner_model (
  // clock
  input wire pclk,
  // arbitration side
  output reg word_sent,
  output reg word_toggle,
  output reg page_received,
  // crossover engine
  output reg auto_swapped
);
  initial begin
    word_sent = 1'b0;
    word_toggle = 1'b0;
    page_received = 1'b0;
    auto_swapped = 1'b0;
  end
  // toggle flips after the pulse so a stale value cannot pass
  task exchange(input t);
    begin
      @(posedge pclk);
      word_sent <= 1'b1;
      word_toggle <= t;
      page_received <= 1'b1;
      @(posedge pclk);
      word_sent <= 1'b0;
      word_toggle <= !t;
      page_received <= 1'b0;
    end
  endtask
  task swap(input s);
    begin
      @(posedge pclk);
      auto_swapped <= s;
    end
  endtask
endmodule // link_partner_model

/* File: np_consts.vh */
// register offsets, field positions and reset values for the next page
// transmit and crossover status register slice; included by every file but the partner model and the bench.
`ifndef NEXT_PAGE_CONSTS_VH
`define NEXT_PAGE_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_AUTONEG_EXPANSION  8'h06
`define IDX_NEXT_PAGE_TRANSMIT 8'h07
`define IDX_PHY_STATUS_SUMMARY 8'h10
`define IDX_PHY_CONTROL        8'h19
`define ADDR_W                 12

// next_page_transmit fields
`define PG_MORE_PAGES_BIT      15
`define PG_RESERVED_BIT        14
`define PG_PAGE_TYPE_BIT       13
`define PG_COMPLY_ACK_BIT      12
`define PG_TOGGLE_BIT          11
`define PG_CODE_MSB            10
`define PG_CODE_W              11
`define PG_MORE_PAGES_RST      1'b0
`define PG_PAGE_TYPE_RST       1'b1
`define PG_COMPLY_ACK_RST      1'b0
`define PG_TOGGLE_RST          1'b0
`define PG_CODE_RST            11'h001

// autoneg_expansion fields
`define EXP_PAGE_RX_BIT        1
`define EXP_NEXT_PAGE_ABLE_BIT 2

// phy_status_summary fields
`define STS_XOVER_BIT          14
`define STS_XOVER_RST          1'b0

// phy_control_register fields
`define CTL_XOVER_EN_BIT       15
`define CTL_XOVER_FORCE_BIT    14
`define CTL_XOVER_EN_RST       1'b1
`define CTL_XOVER_FORCE_RST    1'b0

`endif

/* File: test_autoneg_next_page_tx_regs.sv */
// self-checking bench for the next page transmit register slice
// assumes a zero-wait apb slave and the partner model on the far side
`timescale 1ns/10ps
module test_autoneg_next_page_tx_regs;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg  [31:0] rv;
  reg         re;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire        word_sent;
  wire        word_toggle;
  wire        page_received;
  wire        auto_swapped;
  wire [15:0] next_page_word;
  wire        next_page_loaded_r;
  wire        crossover_status;
  wire        pair_swap_r;
  integer     n_mismatch;
  integer     checked;
  autoneg_next_page_tx_regs i_autoneg_next_page_tx_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .word_sent, .word_toggle, .page_received,
    .next_page_word, .next_page_loaded_r, .auto_swapped,
    .crossover_status, .pair_swap_r);
  link_partner_model i_link_partner_model (
    .pclk, .word_sent, .word_toggle, .page_received, .auto_swapped);
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] e, input er);
    begin
      xfer(1'b0, a, 32'h0000_0000);
      chk("rdata", e, rv & m);
      chk("slverr", {31'h0, er}, {31'h0, re});
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // the run needs under a hundred cycles; this is over forty times that
  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch = n_mismatch + 1;
    $display("[ERR] watchdog exp done got hang");
    close_out;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h01C, 32'hFFFF_FFFF, 32'h0000_2001, 1'b0);
    rd(12'h040, 32'h0000_C000, 32'h0000_0000, 1'b0);
    $display("test reset done");
    xfer(1'b1, 12'h01C, 32'h0000_FFFF);
    rd(12'h01C, 32'hFFFF_FFFF, 32'h0000_B7FF, 1'b0);
    xfer(1'b1, 12'h01C, 32'h0000_5A5A);
    rd(12'h01C, 32'hFFFF_FFFF, 32'h0000_125A, 1'b0);
    chk("loaded", 32'h1, {31'h0, next_page_loaded_r});
    $display("test fields done");
    i_link_partner_model.exchange(1'b0);
    rd(12'h01C, 32'hFFFF_FFFF, 32'h0000_1A5A, 1'b0);
    chk("loaded", 32'h0, {31'h0, next_page_loaded_r});
    xfer(1'b1, 12'h01C, 32'h0000_0000);
    i_link_partner_model.exchange(1'b1);
    rd(12'h01C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
    rd(12'h018, 32'hFFFF_FFFF, 32'h0000_0006, 1'b0);
    rd(12'h018, 32'hFFFF_FFFF, 32'h0000_0004, 1'b0);
    fork
      rd(12'h018, 32'hFFFF_FFFF, 32'h0000_0004, 1'b0);
      i_link_partner_model.exchange(1'b1);
    join
    rd(12'h018, 32'hFFFF_FFFF, 32'h0000_0006, 1'b0);
    $display("test toggle done");
    xfer(1'b1, 12'h040, 32'h0000_FFFF);
    rd(12'h040, 32'h0000_C000, 32'h0000_0000, 1'b0);
    rd(12'h020, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    rd(12'h01D, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    $display("test refused done");
    i_link_partner_model.swap(1'b1);
    rd(12'h040, 32'h0000_4000, 32'h0000_4000, 1'b0);
    chk("swap", 32'h1, {31'h0, pair_swap_r});
    xfer(1'b1, 12'h064, 32'h0000_0000);
    rd(12'h040, 32'h0000_4000, 32'h0000_0000, 1'b0);
    xfer(1'b1, 12'h064, 32'h0000_4000);
    i_link_partner_model.swap(1'b0);
    rd(12'h040, 32'h0000_4000, 32'h0000_4000, 1'b0);
    xfer(1'b1, 12'h064, 32'h0000_8000);
    rd(12'h040, 32'h0000_4000, 32'h0000_0000, 1'b0);
    $display("test crossover done");
    close_out;
  end
endmodule // test_autoneg_next_page_tx_regs

/* File: toggle_tracker.v */
// transmit toggle tracker for next page exchange
// assumes word_sent is a one-cycle pulse from the arbitration logic
`timescale 1ns/10ps
`include "np_consts.vh"
module toggle_tracker (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // link code word just exchanged
  input  wire word_sent,
  input  wire word_toggle,
  // toggle to place in the next word
  output reg  transmit_toggle_r
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_toggle_r <= `PG_TOGGLE_RST;
    end else if (word_sent) begin
      transmit_toggle_r <= ~word_toggle;
    end
  end

endmodule // toggle_tracker
